/* File: fault_bank_pkg.sv */
package fault_bank_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register locations in the volatile map
    localparam logic [ADDR_W-1:0] OFS_POWER_STAGE_FAULT_FLAGS = 12'h0E0;
    localparam logic [ADDR_W-1:0] OFS_CONTROLLER_FAULT_FLAGS = 12'h0E2;
    localparam logic [ADDR_W-1:0] OFS_NONVOLATILE_STORE_FAULT_FLAGS = 12'h32C;

    localparam logic [DATA_W-1:0] POWER_STAGE_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_IDLE_VALUE = 32'h0000_0000;

    // Field positions of the power-stage fault word
    localparam int BIT_DRIVER_FAULT = 31;
    localparam int BIT_OVERCURRENT = 28;
    localparam int BIT_SUPPLY_OVERVOLTAGE = 26;
    localparam int BIT_OVERTEMP_WARNING = 23;
    localparam int BIT_OVERTEMP_SHUTDOWN = 22;
    localparam int BIT_SWITCH_OC_HI = 21;
    localparam int BIT_SWITCH_OC_LO = 16;
    localparam int BIT_REGULATOR_OVERCURRENT = 13;
    localparam int BIT_REGULATOR_UNDERVOLTAGE = 12;
    localparam int BIT_CHARGE_PUMP_UNDERVOLTAGE = 11;

    // Reserved positions, all read as zero
    localparam logic [DATA_W-1:0] POWER_STAGE_RESERVED_MASK = 32'h6B00_C7FF;

    // Cycles from a fault pin to the status word
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] SETTLE_COUNT = 2'h2;

    typedef struct packed {
        logic overcurrent_flag;
        logic supply_overvoltage_flag;
        logic overtemp_warning_flag;
        logic overtemp_shutdown_flag;
        logic phase_c_high_overcurrent;
        logic phase_c_low_overcurrent;
        logic phase_b_high_overcurrent;
        logic phase_b_low_overcurrent;
        logic phase_a_high_overcurrent;
        logic phase_a_low_overcurrent;
        logic regulator_overcurrent_flag;
        logic regulator_undervoltage_flag;
        logic charge_pump_undervoltage_flag;
    } fault_pins_t;

    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage : fault_bank_pkg

/* File: fault_status_register_bank.sv */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Fault registers at E0h, E2h and 32Ch.
// - Power-stage word reads all zeros after reset.
// - Bit 31 is OR of power-stage flags.
// - Bit 28 shows power-stage overcurrent.
// - Bit 26 shows motor supply overvoltage.
// - Bit 23 shows overtemperature warning.
// - Bit 22 shows overtemperature shutdown.
// - Bits 21..16 show per-switch overcurrent, C to A.
// - Bit 13 shows regulator overcurrent.
// - Bit 12 shows regulator undervoltage.
// - Bit 11 shows charge pump undervoltage.
module fault_status_register_bank (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire fault_bank_pkg::fault_pins_t fault_pins,
    input wire logic [31:0] controller_fault_word,
    input wire logic [31:0] nonvolatile_store_fault_word,
    input wire fault_bank_pkg::reg_req_t reg_req,
    output logic [31:0] rdata,
    output logic rd_valid,
    output logic access_error,
    output logic driver_fault
);

    fault_bank_pkg::fault_pins_t sync_a;
    fault_bank_pkg::fault_pins_t sync_b;
    wire logic [30:0] ps_flags;
    wire logic [31:0] ps_word;
    wire logic hit_ps;
    wire logic hit_ctrl;
    wire logic hit_nvm;
    wire logic hit_any;
    wire logic [31:0] next_rdata;
    wire logic next_error;

    // Comparator outputs are asynchronous to the core clock
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= fault_pins;
            sync_b <= sync_a;
        end
    end

    // Live levels, not latched: a flag drops once its cause is gone
    assign ps_flags = {
        2'b00,
        sync_b.overcurrent_flag,
        1'b0,
        sync_b.supply_overvoltage_flag,
        2'b00,
        sync_b.overtemp_warning_flag,
        sync_b.overtemp_shutdown_flag,
        sync_b.phase_c_high_overcurrent,
        sync_b.phase_c_low_overcurrent,
        sync_b.phase_b_high_overcurrent,
        sync_b.phase_b_low_overcurrent,
        sync_b.phase_a_high_overcurrent,
        sync_b.phase_a_low_overcurrent,
        2'b00,
        sync_b.regulator_overcurrent_flag,
        sync_b.regulator_undervoltage_flag,
        sync_b.charge_pump_undervoltage_flag,
        11'h000
    };
    assign ps_word = {|ps_flags, ps_flags};

    assign hit_ps = reg_req.addr == fault_bank_pkg::OFS_POWER_STAGE_FAULT_FLAGS;
    assign hit_ctrl = reg_req.addr == fault_bank_pkg::OFS_CONTROLLER_FAULT_FLAGS;
    assign hit_nvm =
        reg_req.addr == fault_bank_pkg::OFS_NONVOLATILE_STORE_FAULT_FLAGS;
    assign hit_any = hit_ps | hit_ctrl | hit_nvm;

    // Read mux; unmapped offsets answer zero. A read paired with a write
    // is handled as a write, so it must not leak the word either.
    assign next_rdata = (!reg_req.rd_en || reg_req.wr_en) ?
                        fault_bank_pkg::READ_IDLE_VALUE :
                        hit_ps ? ps_word :
                        hit_ctrl ? controller_fault_word :
                        hit_nvm ? nonvolatile_store_fault_word :
                        fault_bank_pkg::READ_IDLE_VALUE;

    // Every write is refused since nothing here is writable
    assign next_error = reg_req.wr_en | (reg_req.rd_en & !hit_any);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= fault_bank_pkg::POWER_STAGE_RESET;
            rd_valid <= 1'b0;
            access_error <= 1'b0;
            driver_fault <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rd_valid <= reg_req.rd_en & !reg_req.wr_en;
            access_error <= next_error;
            driver_fault <= ps_word[fault_bank_pkg::BIT_DRIVER_FAULT];
        end
    end

    // Helper: counts the first two edges after reset, then holds, so pin history is valid
    logic [1:0] settle;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            settle <= 2'h0;
        end else if (settle != fault_bank_pkg::SETTLE_COUNT) begin
            settle <= settle + 2'h1;
        end
    end

    wire logic settled;
    assign settled = settle == fault_bank_pkg::SETTLE_COUNT;

    property p_reset_zero;
        @(posedge core_clk) disable iff (sys_rst)
        $past(sys_rst) |-> ps_word == fault_bank_pkg::POWER_STAGE_RESET
            && rdata == fault_bank_pkg::POWER_STAGE_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("power-stage word not zero after reset");

    property p_read_ps;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_req.rd_en && !reg_req.wr_en && hit_ps)
            |=> rd_valid && !access_error && rdata == $past(ps_word);
    endproperty
    a_read_ps: assert property (p_read_ps)
        else $error("read at E0h did not return power-stage word");

    property p_read_others;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_req.rd_en && !reg_req.wr_en && (hit_ctrl || hit_nvm))
            |=> rdata == ($past(hit_ctrl) ? $past(controller_fault_word)
                          : $past(nonvolatile_store_fault_word));
    endproperty
    a_read_others: assert property (p_read_others)
        else $error("read at E2h or 32Ch returned wrong word");

    property p_summary;
        @(posedge core_clk) disable iff (sys_rst)
        ps_word[fault_bank_pkg::BIT_DRIVER_FAULT]
            == |(ps_word & ~(32'h1 << fault_bank_pkg::BIT_DRIVER_FAULT))
        ##1 driver_fault == $past(ps_word[fault_bank_pkg::BIT_DRIVER_FAULT]);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary bit is not OR of fault flags");

    property p_overcurrent;
        @(posedge core_clk) disable iff (sys_rst)
        settled |-> ps_word[fault_bank_pkg::BIT_OVERCURRENT]
            == $past(fault_pins.overcurrent_flag, 2);
    endproperty
    a_overcurrent: assert property (p_overcurrent)
        else $error("overcurrent bit does not follow its pin");

    property p_overvoltage;
        @(posedge core_clk) disable iff (sys_rst)
        settled |-> ps_word[fault_bank_pkg::BIT_SUPPLY_OVERVOLTAGE]
            == $past(fault_pins.supply_overvoltage_flag, 2);
    endproperty
    a_overvoltage: assert property (p_overvoltage)
        else $error("overvoltage bit does not follow its pin");

    property p_ot_warning;
        @(posedge core_clk) disable iff (sys_rst)
        (settled && fault_pins.overtemp_warning_flag)
            |-> ##2 ps_word[fault_bank_pkg::BIT_OVERTEMP_WARNING];
    endproperty
    a_ot_warning: assert property (p_ot_warning)
        else $error("overtemperature warning not shown");

    property p_ot_shutdown;
        @(posedge core_clk) disable iff (sys_rst)
        settled |-> ps_word[fault_bank_pkg::BIT_OVERTEMP_SHUTDOWN]
            == $past(fault_pins.overtemp_shutdown_flag, 2);
    endproperty
    a_ot_shutdown: assert property (p_ot_shutdown)
        else $error("overtemperature shutdown bit does not follow pin");

    property p_switch_oc;
        @(posedge core_clk) disable iff (sys_rst)
        settled |-> ps_word[fault_bank_pkg::BIT_SWITCH_OC_HI:
                            fault_bank_pkg::BIT_SWITCH_OC_LO]
            == {$past(fault_pins.phase_c_high_overcurrent, 2),
                $past(fault_pins.phase_c_low_overcurrent, 2),
                $past(fault_pins.phase_b_high_overcurrent, 2),
                $past(fault_pins.phase_b_low_overcurrent, 2),
                $past(fault_pins.phase_a_high_overcurrent, 2),
                $past(fault_pins.phase_a_low_overcurrent, 2)};
    endproperty
    a_switch_oc: assert property (p_switch_oc)
        else $error("per-switch overcurrent bits out of order");

    property p_reg_oc;
        @(posedge core_clk) disable iff (sys_rst)
        settled |-> ps_word[fault_bank_pkg::BIT_REGULATOR_OVERCURRENT]
            == $past(fault_pins.regulator_overcurrent_flag, 2);
    endproperty
    a_reg_oc: assert property (p_reg_oc)
        else $error("regulator overcurrent bit does not follow pin");

    property p_reg_uv;
        @(posedge core_clk) disable iff (sys_rst)
        settled |-> ps_word[fault_bank_pkg::BIT_REGULATOR_UNDERVOLTAGE]
            == $past(fault_pins.regulator_undervoltage_flag, 2);
    endproperty
    a_reg_uv: assert property (p_reg_uv)
        else $error("regulator undervoltage bit does not follow pin");

    property p_cp_uv;
        @(posedge core_clk) disable iff (sys_rst)
        settled |-> ps_word[fault_bank_pkg::BIT_CHARGE_PUMP_UNDERVOLTAGE]
            == $past(fault_pins.charge_pump_undervoltage_flag, 2);
    endproperty
    a_cp_uv: assert property (p_cp_uv)
        else $error("charge pump undervoltage bit does not follow pin");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (sys_rst)
        (ps_word & fault_bank_pkg::POWER_STAGE_RESERVED_MASK) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit of power-stage word is set");

    property p_write_refused;
        @(posedge core_clk) disable iff (sys_rst)
        reg_req.wr_en |=> access_error && !rd_valid
            && rdata == fault_bank_pkg::READ_IDLE_VALUE;
    endproperty
    a_write_refused: assert property (p_write_refused)
        else $error("write was not refused");

endmodule : fault_status_register_bank
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic core_clk;
    logic sys_rst;
    fault_bank_pkg::fault_pins_t fault_pins;
    logic [31:0] ctl_word;
    logic [31:0] nv_word;
    fault_bank_pkg::reg_req_t reg_req;
    logic [31:0] rdata;
    logic rd_valid;
    logic access_error;
    logic driver_fault;
    int error_cnt;
    int n_checks;
    // Word position of each pin field, MSB field first
    int pos[13] = '{28, 26, 23, 22, 21, 20, 19, 18, 17, 16, 13, 12, 11};

    fault_status_register_bank u_fault_status_register_bank (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .fault_pins(fault_pins),
        .controller_fault_word(ctl_word),
        .nonvolatile_store_fault_word(nv_word),
        .reg_req(reg_req),
        .rdata(rdata),
        .rd_valid(rd_valid),
        .access_error(access_error),
        .driver_fault(driver_fault)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One request, taken at the next edge, answer judged while it stands;
    // the idle cycle after it keeps two requests from touching one step
    task automatic access(input logic rd, input logic wr,
                          input logic [11:0] a, input logic [31:0] exp,
                          input logic exp_v, input logic exp_e);
        reg_req = '{rd, wr, a, 32'hFFFF_FFFF};
        @(posedge core_clk);
        #1;
        reg_req = '0;
        chk("rdata", exp, rdata);
        chk("rd_valid", {31'h0, exp_v}, {31'h0, rd_valid});
        chk("access_error", {31'h0, exp_e}, {31'h0, access_error});
        @(posedge core_clk);
        #1;
        chk("rdata after", 32'h0, rdata);
        chk("rd_valid after", 32'h0, {31'h0, rd_valid});
        chk("access_error after", 32'h0, {31'h0, access_error});
    endtask : access

    task automatic t_map();
        access(1'b1, 1'b0, 12'h0E0, 32'h0, 1'b1, 1'b0);
        access(1'b1, 1'b0, 12'h0E2, ctl_word, 1'b1, 1'b0);
        access(1'b1, 1'b0, 12'h32C, nv_word, 1'b1, 1'b0);
        access(1'b1, 1'b0, 12'h0E4, 32'h0, 1'b1, 1'b1);
        access(1'b1, 1'b0, 12'h0E1, 32'h0, 1'b1, 1'b1);
        @(posedge core_clk);
        #1;
        chk("rdata idle", 32'h0, rdata);
        chk("rd_valid idle", 32'h0, {31'h0, rd_valid});
    endtask : t_map

    task automatic t_flags();
        for (int i = 0; i < 13; i++) begin
            fault_pins = 13'h1000 >> i;
            repeat (2) @(posedge core_clk);
            #1;
            access(1'b1, 1'b0, 12'h0E0, 32'h8000_0000 | (32'h1 << pos[i]),
                   1'b1, 1'b0);
            chk("driver_fault", 32'h1, {31'h0, driver_fault});
            fault_pins = '0;
            repeat (3) @(posedge core_clk);
            #1;
            chk("driver_fault clr", 32'h0, {31'h0, driver_fault});
            access(1'b1, 1'b0, 12'h0E0, 32'h0, 1'b1, 1'b0);
        end
    endtask : t_flags

    task automatic t_write();
        fault_pins = '1;
        repeat (3) @(posedge core_clk);
        #1;
        // Writes between reads; writes must leave no trace
        access(1'b0, 1'b1, 12'h0E0, 32'h0, 1'b0, 1'b1);
        access(1'b1, 1'b1, 12'h0E0, 32'h0, 1'b0, 1'b1);
        access(1'b0, 1'b1, 12'h0E2, 32'h0, 1'b0, 1'b1);
        access(1'b1, 1'b0, 12'h100, 32'h0, 1'b1, 1'b1);
        access(1'b1, 1'b0, 12'h0E0, 32'h94FF_3800, 1'b1, 1'b0);
        access(1'b1, 1'b0, 12'h0E2, ctl_word, 1'b1, 1'b0);
        // Second reset in mid-run, over a standing answer and live faults
        reg_req = '{1'b1, 1'b0, 12'h0E0, 32'h0000_0000};
        @(posedge core_clk);
        #1;
        reg_req = '0;
        chk("rdata pre rst", 32'h94FF_3800, rdata);
        sys_rst = 1'b1;
        fault_pins = '0;
        #1;
        chk("driver_fault rst", 32'h0, {31'h0, driver_fault});
        chk("rdata rst", 32'h0, rdata);
        chk("rd_valid rst", 32'h0, {31'h0, rd_valid});
        repeat (2) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        @(posedge core_clk);
        #1;
        access(1'b1, 1'b0, 12'h0E0, 32'h0, 1'b1, 1'b0);
    endtask : t_write

    initial begin
        #50000;
        error_cnt++;
        summarize();
    end

    initial begin
        error_cnt = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        fault_pins = '0;
        ctl_word = 32'hA5C3_0F18;
        nv_word = 32'h0000_5A01;
        reg_req = '0;
        repeat (10) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        @(posedge core_clk);
        #1;
        t_map();
        t_flags();
        t_write();
        summarize();
    end
endmodule : testbench
`default_nettype wire
